// File: logic/wws_defines.svh
`ifndef WWS_DEFINES_SVH
`define WWS_DEFINES_SVH
`define WWS_CLK_HZ 25000000
`define WWS_TICK_MS 10
`define WWS_TICK_CYCLES (`WWS_CLK_HZ / 1000 * `WWS_TICK_MS)
`define WWS_TICK_W 18
`define WWS_MIN_PRESS_MS 100
`define WWS_LONG_PRESS_MS 600
`define WWS_START_DELAY_MS 300
`define WWS_SPRAY_MS 1000
`define WWS_MIN_PRESS_T (`WWS_MIN_PRESS_MS / `WWS_TICK_MS)
`define WWS_LONG_PRESS_T (`WWS_LONG_PRESS_MS / `WWS_TICK_MS)
`define WWS_START_DELAY_T (`WWS_START_DELAY_MS / `WWS_TICK_MS)
`define WWS_SPRAY_T (`WWS_SPRAY_MS / `WWS_TICK_MS)
`define WWS_T_W 8
`define WWS_EXTRA_WIPES 3
`define WWS_FIRST_WIPES 4
`define WWS_SECOND_WIPES 3
`define WWS_N_W 3
`endif

// File: logic/wws_pkg.sv
package wws_pkg;
  typedef struct packed {
    logic front_wash;
    logic rear_wash;
    logic auto_wash;
    logic intermittent;
    logic auto_int;
    logic rain_wipe;
    logic speed_int;
    logic park;
  } wws_switch_type;
  typedef struct packed {
    logic wiper_relay;
    logic front_washer;
    logic rear_washer;
    logic auto_int_take;
  } wws_drive_type;
  typedef enum logic [4:0] {
    FW_IDLE  = 5'b0_0001,
    FW_PRESS = 5'b0_0010,
    FW_SHORT = 5'b0_0100,
    FW_EXTRA = 5'b0_1000,
    FW_PARK  = 5'b1_0000
  } wws_front_type;
  typedef enum logic [4:0] {
    AS_IDLE   = 5'b0_0001,
    AS_SPRAY1 = 5'b0_0010,
    AS_WIPE1  = 5'b0_0100,
    AS_SPRAY2 = 5'b0_1000,
    AS_WIPE2  = 5'b1_0000
  } wws_auto_type;
endpackage

// File: logic/wws_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "wws_defines.svh"
module wws_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Ignition and switches from pins
  input wire logic ignition_on,
  input wire wws_pkg::wws_switch_type sw_pins,
  // Relay and motor drives
  output var wws_pkg::wws_drive_type drive
);
  // Three-stage synchronisers; change accepted when stages two and three agree
  localparam int NIN = 9;
  logic [NIN-1:0] s1_reg, s2_reg, s3_reg, in_reg;
  logic [NIN-1:0] s1_next, s2_next, s3_next, in_next;
  logic ign;
  wws_pkg::wws_switch_type sw;
  always_comb begin
    s1_next = {ignition_on, sw_pins};
    s2_next = s1_reg;
    s3_next = s2_reg;
    in_next = in_reg;
    for (int i = 0; i < NIN; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        in_next[i] = s3_reg[i];
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      in_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      in_reg <= in_next;
    end
  end
  assign ign = in_reg[NIN-1];
  assign sw = wws_pkg::wws_switch_type'(in_reg[NIN-2:0]);

  // 10 ms time base
  logic [`WWS_TICK_W-1:0] tdiv_reg, tdiv_next;
  logic tick;
  always_comb begin
    tick = (tdiv_reg == `WWS_TICK_W'(`WWS_TICK_CYCLES - 1));
    tdiv_next = tick ? '0 : tdiv_reg + `WWS_TICK_W'(1);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdiv_reg <= '0;
    end else begin
      tdiv_reg <= tdiv_next;
    end
  end

  // Park contact falling edge marks the end of a wipe cycle
  logic park_d_reg, park_d_next, wipe_done;
  always_comb begin
    park_d_next = sw.park;
    wipe_done = park_d_reg & ~sw.park;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      park_d_reg <= 1'b0;
    end else begin
      park_d_reg <= park_d_next;
    end
  end

  // Front washer and coupled wipe
  wws_pkg::wws_front_type fw_reg, fw_next;
  wws_pkg::wws_auto_type as_reg, as_next;
  logic [`WWS_T_W-1:0] ft_reg, ft_next;
  logic [`WWS_N_W-1:0] fn_reg, fn_next;
  logic frelay_reg, frelay_next, rear_reg, rear_next;
  logic front_busy, auto_busy;
  assign front_busy = (fw_reg != wws_pkg::FW_IDLE);
  assign auto_busy = (as_reg != wws_pkg::AS_IDLE);
  always_comb begin
    fw_next = fw_reg;
    ft_next = ft_reg;
    fn_next = fn_reg;
    frelay_next = frelay_reg;
    if (tick && ft_reg != '1) begin
      ft_next = ft_reg + `WWS_T_W'(1);
    end
    unique case (fw_reg)
      wws_pkg::FW_IDLE: begin
        frelay_next = 1'b0;
        ft_next = '0;
        if (sw.front_wash && !rear_reg && !auto_busy) begin
          fw_next = wws_pkg::FW_PRESS;
        end
      end
      wws_pkg::FW_PRESS: begin
        if (ft_reg >= `WWS_T_W'(`WWS_START_DELAY_T)) begin
          frelay_next = 1'b1;
        end
        if (!sw.front_wash) begin
          if (ft_reg < `WWS_T_W'(`WWS_MIN_PRESS_T)) begin
            fw_next = frelay_reg ? wws_pkg::FW_PARK : wws_pkg::FW_IDLE;
          end else if (ft_reg < `WWS_T_W'(`WWS_LONG_PRESS_T)) begin
            fw_next = wws_pkg::FW_SHORT;
          end else begin
            fw_next = wws_pkg::FW_EXTRA;
            fn_next = '0;
            frelay_next = 1'b1;
          end
        end
      end
      wws_pkg::FW_SHORT: begin
        if (ft_reg >= `WWS_T_W'(`WWS_START_DELAY_T)) begin
          frelay_next = 1'b1;
          fw_next = wws_pkg::FW_PARK;
        end
      end
      wws_pkg::FW_EXTRA: begin
        if (wipe_done) begin
          fn_next = fn_reg + `WWS_N_W'(1);
          if (fn_reg == `WWS_N_W'(`WWS_EXTRA_WIPES - 1)) begin
            frelay_next = 1'b0;
            fw_next = wws_pkg::FW_IDLE;
          end
        end
      end
      wws_pkg::FW_PARK: begin
        if (wipe_done) begin
          frelay_next = 1'b0;
          fw_next = wws_pkg::FW_IDLE;
        end
      end
    endcase
    if (!ign) begin
      fw_next = wws_pkg::FW_IDLE;
      frelay_next = 1'b0;
    end
  end

  // Auto spray-and-wipe sequence
  logic [`WWS_T_W-1:0] at_reg, at_next;
  logic [`WWS_N_W-1:0] an_reg, an_next;
  logic take_reg, take_next, auto_ok;
  always_comb begin
    as_next = as_reg;
    at_next = at_reg;
    an_next = an_reg;
    take_next = take_reg & sw.auto_int;
    // Auto request gated by every mode that overrides it
    auto_ok = sw.auto_wash && !sw.intermittent && !front_busy && !rear_reg
      && !sw.rain_wipe && !sw.speed_int && !sw.auto_int
      && (fw_next == wws_pkg::FW_IDLE); // Front wins a same-cycle tie
    if (tick) begin
      at_next = at_reg + `WWS_T_W'(1);
    end
    unique case (as_reg)
      wws_pkg::AS_IDLE: begin
        at_next = '0;
        an_next = '0;
        if (auto_ok) begin // Only looked at while idle
          as_next = wws_pkg::AS_SPRAY1;
        end
      end
      wws_pkg::AS_SPRAY1: begin
        if (at_reg == `WWS_T_W'(`WWS_SPRAY_T)) begin
          as_next = wws_pkg::AS_WIPE1;
        end
      end
      wws_pkg::AS_WIPE1: begin
        at_next = '0;
        if (wipe_done) begin
          an_next = an_reg + `WWS_N_W'(1);
          if (an_reg == `WWS_N_W'(`WWS_FIRST_WIPES - 1)) begin
            as_next = wws_pkg::AS_SPRAY2;
            an_next = '0;
          end
        end
      end
      wws_pkg::AS_SPRAY2: begin
        if (at_reg == `WWS_T_W'(`WWS_SPRAY_T)) begin
          as_next = wws_pkg::AS_WIPE2;
        end
      end
      wws_pkg::AS_WIPE2: begin
        if (wipe_done) begin
          an_next = an_reg + `WWS_N_W'(1);
          if (an_reg == `WWS_N_W'(`WWS_SECOND_WIPES - 1)) begin
            as_next = wws_pkg::AS_IDLE;
          end
        end
      end
    endcase
    // Auto intermittent during a run aborts the sequence and takes over
    if (auto_busy && sw.auto_int) begin
      as_next = wws_pkg::AS_IDLE;
      take_next = 1'b1;
    end
    if (!ign) begin
      as_next = wws_pkg::AS_IDLE;
      take_next = 1'b0;
    end
  end

  // Rear washer follows its switch unless front or auto washing is active
  always_comb begin
    rear_next = ign && sw.rear_wash && !front_busy && !auto_busy
      && (fw_next == wws_pkg::FW_IDLE) && (as_next == wws_pkg::AS_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fw_reg <= wws_pkg::FW_IDLE;
      ft_reg <= '0;
      fn_reg <= '0;
      frelay_reg <= 1'b0;
      as_reg <= wws_pkg::AS_IDLE;
      at_reg <= '0;
      an_reg <= '0;
      take_reg <= 1'b0;
      rear_reg <= 1'b0;
    end else begin
      fw_reg <= fw_next;
      ft_reg <= ft_next;
      fn_reg <= fn_next;
      frelay_reg <= frelay_next;
      as_reg <= as_next;
      at_reg <= at_next;
      an_reg <= an_next;
      take_reg <= take_next;
      rear_reg <= rear_next;
    end
  end

  // Output drive; washer motor runs while the front switch is held in FW_PRESS
  wws_pkg::wws_drive_type drive_next;
  always_comb begin
    drive_next.wiper_relay = frelay_reg
      | (as_reg == wws_pkg::AS_WIPE1) | (as_reg == wws_pkg::AS_WIPE2);
    drive_next.front_washer = ((fw_reg == wws_pkg::FW_PRESS) & sw.front_wash)
      | (as_reg == wws_pkg::AS_SPRAY1) | (as_reg == wws_pkg::AS_SPRAY2);
    drive_next.rear_washer = rear_reg;
    drive_next.auto_int_take = take_reg;
    if (!ign) begin
      drive_next = '0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive <= '0;
    end else begin
      drive <= drive_next;
    end
  end

  rear_exclusive_a: assert property (@(posedge sys_clk) disable iff (rst)
    drive.rear_washer |-> !front_busy && !auto_busy)
    else $error("rear washer active during front or auto washing");
  rear_follows_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ign && sw.rear_wash && !front_busy && !auto_busy && fw_next == wws_pkg::FW_IDLE
      && as_next == wws_pkg::AS_IDLE) |-> ##1 rear_reg
      ##1 (drive.rear_washer || !$past(ign)))
    else $error("rear washer did not follow switch");
  ign_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ign |-> ##1 (fw_reg == wws_pkg::FW_IDLE && as_reg == wws_pkg::AS_IDLE)
      ##1 (drive == '0))
    else $error("outputs not cleared with ignition off");
  front_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    (fw_reg == wws_pkg::FW_IDLE && (auto_busy || rear_reg)) |-> ##1
      fw_reg == wws_pkg::FW_IDLE)
    else $error("front washer accepted while blocked");
  auto_no_front_a: assert property (@(posedge sys_clk) disable iff (rst)
    (as_reg == wws_pkg::AS_IDLE && front_busy) |-> ##1 as_reg == wws_pkg::AS_IDLE)
    else $error("auto sequence started during front washing");
  auto_no_rain_a: assert property (@(posedge sys_clk) disable iff (rst)
    (as_reg == wws_pkg::AS_IDLE && (sw.rain_wipe || sw.speed_int)) |-> ##1
      as_reg == wws_pkg::AS_IDLE)
    else $error("auto sequence started during rain or speed wiping");
  abort_take_a: assert property (@(posedge sys_clk) disable iff (rst)
    (auto_busy && sw.auto_int && ign) |-> ##1 (as_reg == wws_pkg::AS_IDLE && take_reg)
      ##1 (drive.auto_int_take || !$past(ign)))
    else $error("auto intermittent did not abort sequence");
  relay_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(frelay_reg) && fw_reg != wws_pkg::FW_EXTRA) |->
      ft_reg >= `WWS_T_W'(`WWS_START_DELAY_T))
    else $error("wiper relay before start delay");
  extra_three_a: assert property (@(posedge sys_clk) disable iff (rst)
    (fw_reg == wws_pkg::FW_EXTRA) |-> fn_reg < `WWS_N_W'(`WWS_EXTRA_WIPES))
    else $error("too many extra wipes");
  spray_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(as_reg == wws_pkg::AS_WIPE1) |-> $past(at_reg) == `WWS_T_W'(`WWS_SPRAY_T))
    else $error("first spray not one second");

  short_c: cover property (@(posedge sys_clk) disable iff (rst)
    fw_reg == wws_pkg::FW_SHORT);
  long_c: cover property (@(posedge sys_clk) disable iff (rst)
    fw_reg == wws_pkg::FW_EXTRA ##1 fw_reg == wws_pkg::FW_IDLE);
  auto_done_c: cover property (@(posedge sys_clk) disable iff (rst)
    as_reg == wws_pkg::AS_WIPE2 ##1 as_reg == wws_pkg::AS_IDLE);
  rear_c: cover property (@(posedge sys_clk) disable iff (rst) drive.rear_washer);
endmodule
`default_nettype wire

// File: tb/wws_park_model.sv
`timescale 1ns/10ps
`default_nettype none
module wws_park_model #(
  parameter int SWEEP = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Relay from the block
  input wire logic wiper_relay,
  // Park contact, high while off park
  output var logic park
);
  int cnt_reg;
  int cnt_next;
  // A sweep once begun always runs to park, as a real motor would
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_reg != 0 || wiper_relay) begin
      cnt_next = (cnt_reg == SWEEP - 1) ? 0 : cnt_reg + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= 0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign park = (cnt_reg != 0);
endmodule
`default_nettype wire

// File: tb/wws_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module wws_sequencer_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ignition_on = 1'b0;
  logic park;
  wws_pkg::wws_switch_type sw_drv = '0;
  wws_pkg::wws_switch_type sw_pins;
  wws_pkg::wws_drive_type drive;
  int n_mismatch = 0;
  int total_checks = 0;
  always #20 sys_clk = ~sys_clk;
  assign sw_pins = {sw_drv[7:1], park};
  wws_sequencer u_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .ignition_on(ignition_on),
    .sw_pins(sw_pins),
    .drive(drive)
  );
  wws_park_model #(.SWEEP(16)) u_park (
    .sys_clk(sys_clk),
    .rst(rst),
    .wiper_relay(drive.wiper_relay),
    .park(park)
  );
  task automatic check_drive(input logic [3:0] exp, input string what);
    total_checks++;
    if (drive !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %b", $time, what, drive);
    end
  endtask
  // Pin changes need sync stages plus output register
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic pulse_auto();
    sw_drv.auto_wash = 1'b1;
    repeat (8) @(negedge sys_clk);
    sw_drv.auto_wash = 1'b0;
    settle();
  endtask
  task automatic t_rear();
    sw_drv.rear_wash = 1'b1;
    settle();
    check_drive(4'h2, "rear on");
    sw_drv.rear_wash = 1'b0;
    settle();
    check_drive(4'h0, "rear off");
    $display("test rear done");
  endtask
  task automatic t_rear_blocks();
    sw_drv.rear_wash = 1'b1;
    settle();
    sw_drv.front_wash = 1'b1;
    settle();
    check_drive(4'h2, "front during rear");
    sw_drv.front_wash = 1'b0;
    pulse_auto();
    check_drive(4'h2, "auto during rear");
    sw_drv.rear_wash = 1'b0;
    settle();
    check_drive(4'h0, "rear released");
    $display("test rear_blocks done");
  endtask
  task automatic t_front_blocks();
    sw_drv.front_wash = 1'b1;
    settle();
    sw_drv.rear_wash = 1'b1;
    settle();
    check_drive(4'h4, "rear during front");
    pulse_auto();
    sw_drv.front_wash = 1'b0;
    sw_drv.rear_wash = 1'b0;
    settle();
    check_drive(4'h0, "auto during front");
    $display("test front_blocks done");
  endtask
  task automatic t_same_time();
    sw_drv.front_wash = 1'b1;
    sw_drv.rear_wash = 1'b1;
    settle();
    check_drive(4'h4, "front and rear together");
    sw_drv.front_wash = 1'b0;
    sw_drv.rear_wash = 1'b0;
    settle();
    check_drive(4'h0, "front tie released");
    sw_drv.front_wash = 1'b1;
    pulse_auto();
    sw_drv.front_wash = 1'b0;
    settle();
    check_drive(4'h0, "auto with front");
    sw_drv.rear_wash = 1'b1;
    pulse_auto();
    check_drive(4'h4, "auto and rear together");
    sw_drv.rear_wash = 1'b0;
    sw_drv.auto_int = 1'b1;
    settle();
    check_drive(4'h1, "tie sequence aborted");
    sw_drv.auto_int = 1'b0;
    settle();
    check_drive(4'h0, "tie cleanup");
    $display("test same_time done");
  endtask
  task automatic t_auto_abort();
    pulse_auto();
    check_drive(4'h4, "auto spray");
    sw_drv.rear_wash = 1'b1;
    settle();
    check_drive(4'h4, "rear during auto");
    sw_drv.rear_wash = 1'b0;
    sw_drv.auto_int = 1'b1;
    settle();
    check_drive(4'h1, "auto int takes over");
    sw_drv.auto_int = 1'b0;
    settle();
    check_drive(4'h0, "after abort");
    $display("test auto_abort done");
  endtask
  task automatic t_auto_refused();
    int bits [4] = '{4, 3, 2, 1};
    foreach (bits[i]) begin
      sw_drv[bits[i]] = 1'b1;
      settle();
      pulse_auto();
      check_drive(4'h0, "auto refused");
      sw_drv[bits[i]] = 1'b0;
      settle();
    end
    $display("test auto_refused done");
  endtask
  task automatic t_ignition();
    pulse_auto();
    ignition_on = 1'b0;
    settle();
    check_drive(4'h0, "ignition off");
    ignition_on = 1'b1;
    settle();
    check_drive(4'h0, "sequence cancelled");
    $display("test ignition done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    ignition_on = 1'b1;
    settle();
    check_drive(4'h0, "idle after reset");
    t_rear();
    t_rear_blocks();
    t_front_blocks();
    t_same_time();
    t_auto_abort();
    t_auto_refused();
    t_ignition();
    results();
  end
endmodule
`default_nettype wire
